/* File: rtl/tbfcd_pkg.sv */
// Constants shared by the transmit-byte and frequency command decoder
package tbfcd_pkg;

    // Serial command word
    localparam int          WORD_BITS     = 16;
    localparam logic [4:0]  WORD_BITS_C   = 5'h10;
    localparam logic [4:0]  CNT_SAT       = 5'h11;

    // Command code bits and their positions
    localparam logic [7:0]  CMD_TXB_CODE  = 8'hb8;
    localparam int          CMD_TXB_LSB   = 8;
    localparam logic [3:0]  CMD_CFS_CODE  = 4'ha;
    localparam int          CMD_CFS_LSB   = 12;
    localparam logic [4:0]  CMD_RXC_CODE  = 5'h12;
    localparam int          CMD_RXC_LSB   = 11;

    // Power-on register values
    localparam logic [15:0] TXB_POR       = 16'hb8aa;
    localparam logic [15:0] CFS_POR       = 16'ha680;
    localparam logic [15:0] RXC_POR       = 16'h9080;

    // Permitted frequency value range, inclusive
    localparam logic [11:0] FREQUENCY_VALUE_MIN      = 12'h060;
    localparam logic [11:0] FREQUENCY_VALUE_MAX      = 12'hf3f;

    // Frequency arithmetic, all in Hz
    localparam logic [31:0] DEV_STEP_HZ   = 32'h00003a98;
    localparam logic [31:0] FREQUENCY_VALUE_STEP_HZ  = 32'h000009c4;
    localparam logic [31:0] BAND_UNIT_HZ  = 32'h00989680;

    // Band select codes and band constants
    localparam logic [1:0]  BAND_433      = 2'h0;
    localparam logic [1:0]  BAND_868      = 2'h1;
    localparam logic [1:0]  BAND_915      = 2'h2;
    localparam logic [31:0] MULT_433      = 32'h00000001;
    localparam logic [31:0] MULT_868      = 32'h00000002;
    localparam logic [31:0] MULT_915      = 32'h00000003;
    localparam logic [31:0] OFF_433       = 32'h0000002b;
    localparam logic [31:0] OFF_868       = 32'h0000002b;
    localparam logic [31:0] OFF_915       = 32'h0000001e;

    // Transmit byte buffer
    localparam int          FIFO_DEPTH    = 8;
    localparam int          BYTE_BITS     = 8;
    localparam logic [2:0]  LAST_BIT      = 3'h7;

    // Transmit serialiser states, Gray coded
    typedef enum logic [0:0] {
        TX_IDLE  = 1'b0,
        TX_SHIFT = 1'b1
    } tbfcd_tx_state_t;

endpackage

/* File: rtl/tbfcd_fifo.sv */
// Synchronous FIFO holding transmit bytes
`timescale 1ns/1ps
module tbfcd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,      // System clock
    input  wire logic             rst,       // Async reset, active high
    input  wire logic             inValid,   // Write request
    output logic                  inReady,   // Space available
    input  wire logic [WIDTH-1:0] inData,    // Write data
    output logic                  outValid,  // Data available
    input  wire logic             outReady,  // Read accept
    output logic      [WIDTH-1:0] outData    // Head entry
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r, wrPtr_nxt;
    logic [AW-1:0]    rdPtr_r, rdPtr_nxt;
    logic [AW:0]      count_r, count_nxt;
    logic             doPush;
    logic             doPop;

    // Handshakes and pointer updates
    always_comb begin
        inReady   = (count_r < (AW+1)'(DEPTH));   // Full once DEPTH entries held
        outValid  = (count_r != '0);
        outData   = mem[rdPtr_r];
        doPush    = inValid && inReady;
        doPop     = outValid && outReady;
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (doPush) begin
            wrPtr_nxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
        end
        if (doPop) begin
            rdPtr_nxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
        end
        if (doPush && !doPop) begin
            count_nxt = count_r + 1'b1;
        end else if (doPop && !doPush) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // Pointer and count registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge mclk) begin
        if (doPush) begin
            mem[wrPtr_r] <= inData;
        end
    end

endmodule

/* File: rtl/tbfcd_decode.sv */
// Serial command decoder with transmit byte path and FSK frequency forming
`timescale 1ns/1ps
module tbfcd_decode (
    input  wire logic        mclk,                  // System clock, 20 MHz
    input  wire logic        rst,                   // Async reset, active high
    input  wire logic        sck,                   // Serial clock pin
    input  wire logic        sdi,                   // Serial data in pin
    input  wire logic        csN,                   // Chip select pin, active low
    input  wire logic        fskDataPin,            // Manual FSK data pin
    input  wire logic        txRegEnable,           // Transmit register enable
    input  wire logic        bitTick,               // One-cycle data rate strobe
    input  wire logic [1:0]  bandSel,               // Band select
    input  wire logic [3:0]  deviationField,        // Deviation field
    input  wire logic        modulationPolarity,    // Modulation polarity
    output logic      [15:0] transmitByte,          // Transmit byte register
    output logic      [15:0] centerFreqSet,         // Centre frequency register
    output logic      [15:0] receiverConfiguration, // Receiver configuration
    output logic             txFifoFull,            // Byte buffer full
    output logic             modData,               // Current modulating bit
    output logic             freqNegative,          // Offset below centre
    output logic      [31:0] centerFreqHz,          // Channel centre in Hz
    output logic      [31:0] outputFreqHz           // FSK output in Hz
);

    // Pin synchronisers, three stages on sck and csN for edge detection, two on sdi and the FSK pin
    logic [2:0]  sckS_r, sckS_nxt;
    logic [2:0]  csS_r, csS_nxt;
    logic [1:0]  sdiS_r, sdiS_nxt;
    logic [1:0]  fskS_r, fskS_nxt;

    // Command shift state
    logic [15:0] shift_r, shift_nxt;
    logic [4:0]  bitCnt_r, bitCnt_nxt;
    logic        sckRise;
    logic        csRise;
    logic        csFall;
    logic        frameDone;
    logic        isTxb;
    logic        isCfs;
    logic        isRxc;
    logic        fvalOk;

    // Registers reached by commands
    logic [15:0] txb_r, txb_nxt;
    logic [15:0] cfs_r, cfs_nxt;
    logic [15:0] rxc_r, rxc_nxt;

    // Pending push toward the byte buffer
    logic        pend_r, pend_nxt;
    logic [7:0]  pendByte_r, pendByte_nxt;
    logic        fifoInReady;
    logic        fifoOutValid;
    logic        fifoOutReady;
    logic [7:0]  fifoOutData;

    // Transmit serialiser
    tbfcd_pkg::tbfcd_tx_state_t txState_r, txState_nxt;
    logic [7:0]  txShift_r, txShift_nxt;
    logic [2:0]  bitIdx_r, bitIdx_nxt;
    logic        modData_r, modData_nxt;
    logic        loadByte;

    // Frequency forming
    logic [31:0] bandMult;
    logic [31:0] bandOff;
    logic [31:0] centreHz;
    logic [31:0] devHz;
    logic        negSign;
    logic [31:0] centre_r, centre_nxt;
    logic [31:0] outHz_r, outHz_nxt;
    logic        neg_r, neg_nxt;

    // Edges seen on the synchronised serial pins
    assign sckRise   = sckS_r[1] && !sckS_r[2];
    assign csRise    = csS_r[1] && !csS_r[2];
    assign csFall    = !csS_r[1] && csS_r[2];
    assign frameDone = csRise && (bitCnt_r == tbfcd_pkg::WORD_BITS_C);

    // Command code decode on the finished word
    assign isTxb  = shift_r[15:tbfcd_pkg::CMD_TXB_LSB] == tbfcd_pkg::CMD_TXB_CODE;
    assign isCfs  = shift_r[15:tbfcd_pkg::CMD_CFS_LSB] == tbfcd_pkg::CMD_CFS_CODE;
    assign isRxc  = shift_r[15:tbfcd_pkg::CMD_RXC_LSB] == tbfcd_pkg::CMD_RXC_CODE;
    assign fvalOk = (shift_r[11:0] >= tbfcd_pkg::FREQUENCY_VALUE_MIN)
                 && (shift_r[11:0] <= tbfcd_pkg::FREQUENCY_VALUE_MAX);

    // Synchroniser chains
    always_comb begin
        sckS_nxt = {sckS_r[1:0], sck};
        csS_nxt  = {csS_r[1:0], csN};
        sdiS_nxt = {sdiS_r[0], sdi};
        fskS_nxt = {fskS_r[0], fskDataPin};
    end

    // Word shifting and register writes
    always_comb begin
        shift_nxt    = shift_r;
        bitCnt_nxt   = bitCnt_r;
        txb_nxt      = txb_r;
        cfs_nxt      = cfs_r;
        rxc_nxt      = rxc_r;
        pend_nxt     = pend_r;
        pendByte_nxt = pendByte_r;
        if (csFall) begin
            bitCnt_nxt = '0;
        end else if (sckRise && !csS_r[1]) begin
            shift_nxt = {shift_r[14:0], sdiS_r[1]};
            if (bitCnt_r != tbfcd_pkg::CNT_SAT) begin
                bitCnt_nxt = bitCnt_r + 1'b1;
            end
        end
        // Pending byte leaves once the buffer accepts it
        if (pend_r && fifoInReady) begin
            pend_nxt = 1'b0;
        end
        if (frameDone && isTxb) begin
            txb_nxt      = shift_r;
            pend_nxt     = 1'b1;
            pendByte_nxt = shift_r[7:0];
        end
        if (frameDone && isCfs && fvalOk) begin
            cfs_nxt = shift_r;
        end
        if (frameDone && isRxc) begin
            rxc_nxt = shift_r;
        end
    end

    // Byte buffer between command path and serialiser
    tbfcd_fifo #(
        .WIDTH (tbfcd_pkg::BYTE_BITS),
        .DEPTH (tbfcd_pkg::FIFO_DEPTH)
    ) u_txFifo (
        .mclk     (mclk),
        .rst      (rst),
        .inValid  (pend_r),
        .inReady  (fifoInReady),
        .inData   (pendByte_r),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (fifoOutData)
    );

    // Byte loads happen at a byte boundary while enabled
    assign loadByte     = txRegEnable && bitTick
                       && ((txState_r == tbfcd_pkg::TX_IDLE) || (bitIdx_r == tbfcd_pkg::LAST_BIT));
    assign fifoOutReady = loadByte;

    // Transmit serialiser and data source select
    always_comb begin
        txState_nxt = txState_r;
        txShift_nxt = txShift_r;
        bitIdx_nxt  = bitIdx_r;
        unique case (txState_r)
            tbfcd_pkg::TX_IDLE: begin
                if (loadByte) begin
                    txState_nxt = tbfcd_pkg::TX_SHIFT;
                end
            end
            tbfcd_pkg::TX_SHIFT: begin
                if (!txRegEnable) begin
                    txState_nxt = tbfcd_pkg::TX_IDLE;
                end
            end
        endcase
        if (loadByte) begin
            // Empty buffer repeats the stored byte as filler
            txShift_nxt = fifoOutValid ? fifoOutData : txb_r[7:0];
            bitIdx_nxt  = '0;
        end else if (txState_r == tbfcd_pkg::TX_SHIFT && bitTick) begin
            txShift_nxt = {txShift_r[6:0], 1'b0};
            bitIdx_nxt  = bitIdx_r + 1'b1;
        end
        modData_nxt = txRegEnable ? txShift_r[7] : fskS_r[1];
    end

    // Band constants
    always_comb begin
        unique case (bandSel)
            tbfcd_pkg::BAND_868: begin
                bandMult = tbfcd_pkg::MULT_868;
                bandOff  = tbfcd_pkg::OFF_868;
            end
            tbfcd_pkg::BAND_915: begin
                bandMult = tbfcd_pkg::MULT_915;
                bandOff  = tbfcd_pkg::OFF_915;
            end
            default: begin
                bandMult = tbfcd_pkg::MULT_433;
                bandOff  = tbfcd_pkg::OFF_433;
            end
        endcase
    end

    // Centre, deviation and output frequency
    always_comb begin
        centreHz   = bandMult * (bandOff * tbfcd_pkg::BAND_UNIT_HZ
                   + {20'h00000, cfs_r[11:0]} * tbfcd_pkg::FREQUENCY_VALUE_STEP_HZ);
        devHz      = ({28'h0000000, deviationField} + 32'h00000001)
                   * tbfcd_pkg::DEV_STEP_HZ;
        negSign    = modulationPolarity ^ modData_r;
        centre_nxt = centreHz;
        neg_nxt    = negSign;
        outHz_nxt  = negSign ? centreHz - devHz : centreHz + devHz;
    end

    // State registers with power-on values
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sckS_r     <= '0;
            csS_r      <= 3'h7;
            sdiS_r     <= '0;
            fskS_r     <= '0;
            shift_r    <= '0;
            bitCnt_r   <= '0;
            txb_r      <= tbfcd_pkg::TXB_POR;
            cfs_r      <= tbfcd_pkg::CFS_POR;
            rxc_r      <= tbfcd_pkg::RXC_POR;
            pend_r     <= 1'b0;
            pendByte_r <= '0;
            txState_r  <= tbfcd_pkg::TX_IDLE;
            txShift_r  <= '0;
            bitIdx_r   <= '0;
            modData_r  <= 1'b0;
            centre_r   <= '0;
            outHz_r    <= '0;
            neg_r      <= 1'b0;
        end else begin
            sckS_r     <= sckS_nxt;
            csS_r      <= csS_nxt;
            sdiS_r     <= sdiS_nxt;
            fskS_r     <= fskS_nxt;
            shift_r    <= shift_nxt;
            bitCnt_r   <= bitCnt_nxt;
            txb_r      <= txb_nxt;
            cfs_r      <= cfs_nxt;
            rxc_r      <= rxc_nxt;
            pend_r     <= pend_nxt;
            pendByte_r <= pendByte_nxt;
            txState_r  <= txState_nxt;
            txShift_r  <= txShift_nxt;
            bitIdx_r   <= bitIdx_nxt;
            modData_r  <= modData_nxt;
            centre_r   <= centre_nxt;
            outHz_r    <= outHz_nxt;
            neg_r      <= neg_nxt;
        end
    end

    // Output drive
    assign transmitByte          = txb_r;
    assign centerFreqSet         = cfs_r;
    assign receiverConfiguration = rxc_r;
    assign txFifoFull            = !fifoInReady;
    assign modData               = modData_r;
    assign freqNegative          = neg_r;
    assign centerFreqHz          = centre_r;
    assign outputFreqHz          = outHz_r;

    // Checks on decoding and frequency forming
    AST_TXB_WRITE: assert property (@(posedge mclk) disable iff (rst)
        (frameDone && isTxb) |=> (txb_r == $past(shift_r)) && pend_r)
        else $error("transmit byte command not stored");

    AST_CFS_WRITE: assert property (@(posedge mclk) disable iff (rst)
        (frameDone && isCfs && fvalOk) |=> cfs_r == $past(shift_r))
        else $error("centre frequency command not stored");

    AST_CFS_KEEP: assert property (@(posedge mclk) disable iff (rst)
        (frameDone && isCfs && !fvalOk) |=> $stable(cfs_r))
        else $error("out of range frequency value changed register");

    AST_RXC_WRITE: assert property (@(posedge mclk) disable iff (rst)
        (frameDone && isRxc) |=> rxc_r == $past(shift_r))
        else $error("receiver configuration command not stored");

    AST_FRAME_LEN: assert property (@(posedge mclk) disable iff (rst)
        (csRise && bitCnt_r != tbfcd_pkg::WORD_BITS_C) |=> $stable(txb_r) && $stable(rxc_r))
        else $error("short or long word changed a register");

    AST_DATA_SRC: assert property (@(posedge mclk) disable iff (rst)
        (!txRegEnable) |-> !fifoOutReady ##1 (modData_r == $past(fskS_r[1])))
        else $error("data source not the pin while register disabled");

    AST_SIGN: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> neg_r == ($past(modulationPolarity) ^ $past(modData_r)))
        else $error("offset direction wrong");

    AST_DEV_NEG: assert property (@(posedge mclk) disable iff (rst)
        ##1 neg_r |-> centre_r - outHz_r == ({28'h0000000, $past(deviationField)} + 32'h00000001) * 32'h00003a98)
        else $error("negative deviation magnitude wrong");

    AST_DEV_POS: assert property (@(posedge mclk) disable iff (rst)
        ##1 !neg_r |-> outHz_r - centre_r == ({28'h0000000, $past(deviationField)} + 32'h00000001) * 32'h00003a98)
        else $error("positive deviation magnitude wrong");

    AST_BAND: assert property (@(posedge mclk) disable iff (rst)
        (bandSel == tbfcd_pkg::BAND_915) |=> centre_r == 32'h00000003 * (32'h11e1a300
                                              + {20'h00000, $past(cfs_r[11:0])} * 32'h000009c4))
        else $error("915 MHz band centre frequency wrong");

    // Serialiser, buffer and register hold checks; a stale pending byte would resend old data
    AST_LOAD_START: assert property (@(posedge mclk) disable iff (rst)
        loadByte |=> (txState_r == tbfcd_pkg::TX_SHIFT) && (bitIdx_r == 3'h0))
        else $error("byte load did not restart the serialiser");

    AST_LOAD_DATA: assert property (@(posedge mclk) disable iff (rst)
        (loadByte && fifoOutValid) |=> txShift_r == $past(fifoOutData))
        else $error("buffered byte not loaded into serialiser");

    AST_LOAD_FILL: assert property (@(posedge mclk) disable iff (rst)
        (loadByte && !fifoOutValid) |=> txShift_r == $past(txb_r[7:0]))
        else $error("filler byte not taken from transmit register");

    AST_PEND_HOLD: assert property (@(posedge mclk) disable iff (rst)
        (pend_r && !fifoInReady && !(frameDone && isTxb)) |=> pend_r && $stable(pendByte_r))
        else $error("pending byte lost while buffer full");

    AST_TXB_OTHER: assert property (@(posedge mclk) disable iff (rst)
        (!(frameDone && isTxb)) |=> $stable(txb_r))
        else $error("transmit byte changed without its command");

    AST_CFS_OTHER: assert property (@(posedge mclk) disable iff (rst)
        (!(frameDone && isCfs && fvalOk)) |=> $stable(cfs_r))
        else $error("centre frequency changed without valid command");

endmodule

/* File: sim/tbfcd_host.sv */
// Host model clocking command words into the decoder
`timescale 1ns/1ps
module tbfcd_host (
    input  wire logic        mclk,  // System clock
    input  wire logic        go,    // Frame request
    input  wire logic [4:0]  nBits, // Bits to clock
    input  wire logic [15:0] word,  // Command word
    output logic             sck,   // Serial clock
    output logic             sdi,   // Serial data
    output logic             csN,   // Chip select, active low
    output logic             busy   // Frame in progress
);
    logic [31:0] sh;
    int          i;

    // Idle pins before the first frame
    initial begin
        sck  = 1'b0;
        sdi  = 1'b0;
        csN  = 1'b1;
        busy = 1'b0;
    end

    // One frame per request, four cycles per clock phase
    always @(posedge mclk) begin
        if (go && !busy) begin
            busy = 1'b1;
            sh   = {word, 16'h0000};
            @(negedge mclk);
            csN = 1'b0;
            repeat (4) @(negedge mclk);
            for (i = 0; i < nBits; i++) begin
                sdi = sh[31]; // MSB first
                sh  = sh << 1;
                repeat (4) @(negedge mclk);
                sck = 1'b1;
                repeat (4) @(negedge mclk);
                sck = 1'b0;
            end
            repeat (4) @(negedge mclk);
            csN = 1'b1;
            sdi = ~sdi; // Released line no longer holds its value
            repeat (4) @(negedge mclk);
            busy = 1'b0;
        end
    end
endmodule

/* File: sim/tbfcd_decode_test.sv */
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module tbfcd_decode_test;
    typedef struct packed {
        logic [15:0] word;
        logic [4:0]  nBits;
        logic [15:0] txb;
        logic [15:0] cfs;
        logic [15:0] rxc;
    } tbfcd_row_t;

    logic        mclk, rst, sck, sdi, csN, fskDataPin, txRegEnable, bitTick, modPol, go, busy, full, modData, neg;
    logic [1:0]  bandSel;
    logic [3:0]  devField;
    logic [4:0]  nBits;
    logic [15:0] word, txb, cfs, rxc;
    logic [31:0] cfHz, outHz, off, cfx;
    int          errTotal, numChecks, b;

    // Command rows: word, bits clocked, expected registers after it
    tbfcd_row_t  rows [10] = '{
        '{16'ha7d0, 5'h10, 16'hb8aa, 16'ha7d0, 16'h9080},
        '{16'ha05f, 5'h10, 16'hb8aa, 16'ha7d0, 16'h9080},
        '{16'haf40, 5'h10, 16'hb8aa, 16'ha7d0, 16'h9080},
        '{16'ha060, 5'h10, 16'hb8aa, 16'ha060, 16'h9080},
        '{16'haf3f, 5'h10, 16'hb8aa, 16'haf3f, 16'h9080},
        '{16'hb855, 5'h10, 16'hb855, 16'haf3f, 16'h9080},
        '{16'h9123, 5'h10, 16'hb855, 16'haf3f, 16'h9123},
        '{16'hb9aa, 5'h10, 16'hb855, 16'haf3f, 16'h9123}, // Unknown code
        '{16'ha123, 5'h0f, 16'hb855, 16'haf3f, 16'h9123},
        '{16'ha123, 5'h11, 16'hb855, 16'haf3f, 16'h9123}
    };

    tbfcd_host host (.mclk(mclk), .go(go), .nBits(nBits), .word(word), .sck(sck), .sdi(sdi), .csN(csN), .busy(busy));

    tbfcd_decode dut (.mclk(mclk), .rst(rst), .sck(sck), .sdi(sdi), .csN(csN), .fskDataPin(fskDataPin),
        .txRegEnable(txRegEnable), .bitTick(bitTick), .bandSel(bandSel), .deviationField(devField),
        .modulationPolarity(modPol), .transmitByte(txb), .centerFreqSet(cfs), .receiverConfiguration(rxc),
        .txFifoFull(full), .modData(modData), .freqNegative(neg), .centerFreqHz(cfHz), .outputFreqHz(outHz));

    // Expected centre frequency in Hz
    function automatic logic [31:0] cf_exp(input logic [1:0] bs, input logic [11:0] f);
        logic [31:0] m;
        logic [31:0] o;
        m = (bs == 2'h1) ? 32'h2 : (bs == 2'h2) ? 32'h3 : 32'h1;
        o = (bs == 2'h2) ? 32'h1e : 32'h2b;
        return m * (o * 32'h00989680 + {20'h00000, f} * 32'h9c4);
    endfunction

    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        chk32(what, {16'h0000, exp}, {16'h0000, got});
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        chk32(what, {31'h00000000, exp}, {31'h00000000, got});
    endtask

    task automatic closeOut();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (8) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
    endtask

    // One frame through the host model, bounded wait
    task automatic send(input logic [15:0] w, input logic [4:0] n);
        int k;
        word  = w;
        nBits = n;
        go    = 1'b1;
        k     = 0;
        @(negedge mclk);
        go = 1'b0;
        while (busy !== 1'b0 && k < 400) begin
            @(negedge mclk);
            k++;
        end
        chk1("frame end", 1'b0, busy);
        repeat (8) @(negedge mclk);
    endtask

    // Clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Watchdog, well past the expected run length
    initial begin
        #(20000 * 50);
        errTotal++;
        closeOut();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        fskDataPin = 1'b0;
        txRegEnable = 1'b0;
        bitTick = 1'b0;
        bandSel = 2'h0;
        devField = 4'h0;
        modPol = 1'b0;
        go = 1'b0;
        word = 16'h0000;
        nBits = 5'h00;
        do_reset();
        chk16("transmit byte", 16'hb8aa, txb);
        chk16("centre set", 16'ha680, cfs);
        chk16("receiver config", 16'h9080, rxc);
        chk32("centre Hz", cf_exp(2'h0, 12'h680), cfHz);
        foreach (rows[r]) begin
            send(rows[r].word, rows[r].nBits);
            chk16("transmit byte", rows[r].txb, txb);
            chk16("centre set", rows[r].cfs, cfs);
            chk16("receiver config", rows[r].rxc, rxc);
        end
        // Every band, including the spare code
        for (b = 0; b < 4; b++) begin
            bandSel = b[1:0];
            repeat (3) @(negedge mclk);
            chk32("centre Hz", cf_exp(b[1:0], 12'hf3f), cfHz);
        end
        // Manual data with deviation extremes and both polarities
        bandSel = 2'h0;
        cfx = cf_exp(2'h0, 12'hf3f);
        for (b = 0; b < 8; b++) begin
            devField = b[0] ? 4'hf : 4'h0;
            modPol = b[1];
            fskDataPin = b[2];
            repeat (6) @(negedge mclk);
            off = ({28'h0000000, devField} + 32'h1) * 32'h3a98;
            chk1("mod data", b[2], modData);
            chk1("negative", b[1] ^ b[2], neg);
            chk32("output Hz", (b[1] ^ b[2]) ? cfx - off : cfx + off, outHz);
        end
        // Fill the byte buffer while it is not drained
        do_reset();
        for (b = 1; b <= 9; b++) begin
            chk1("buffer full", b > 8, full);
            send({8'hb8, b[7:0] * 8'h11}, 5'h10);
        end
        chk1("buffer full", 1'b1, full);
        // Drain it bit by bit, then the filler byte
        txRegEnable = 1'b1;
        for (b = 0; b < 80; b++) begin
            bitTick = 1'b1;
            @(negedge mclk);
            bitTick = 1'b0;
            repeat (3) @(negedge mclk);
            off = ((b / 8 < 9) ? b / 8 + 1 : 9) * 8'h11;
            chk1("tx bit", off[7 - b % 8], modData);
            repeat (4) @(negedge mclk);
        end
        chk1("buffer full", 1'b0, full);
        closeOut();
    end
endmodule
